/* core/bdl_dev.sv */
// Device end: register window and bootloader command interpreter.
// Assumes link pins are asynchronous to clk; rst_b stands for the enable pin.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module bdl_dev
  import bdl_pkg::*;
#(
  parameter logic [7:0] APP_ID = 8'h01  // Arbitrary value
) (
  input  wire logic clk,
  input  wire logic rst_b,
  bdl_link_if.dev   lnk,
  output logic       ram_we,
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic       remap,
  output logic       sys_reset,
  output logic       dl_init,
  output logic [7:0] dl_seed
);
  import bdl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic cs_s1, cs_s2, ck_s1, ck_s2, ck_s3, mo_s1, mo_s2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      mo_s1 <= 1'b0;
      mo_s2 <= 1'b0;
    end else begin
      cs_s1 <= lnk.link_cs_b;
      cs_s2 <= cs_s1;
      ck_s1 <= lnk.link_clk;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      mo_s1 <= lnk.link_mosi;
      mo_s2 <= mo_s1;
    end
  end
  wire logic rise = ck_s2 & ~ck_s3;
  wire logic fall = ~ck_s2 & ck_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] mem [DATA_BYTES];
  logic [7:0] cmd_reg, cmd_next, size_reg, size_next, csum_reg, csum_next;
  logic [7:0] status_reg, status_next, appid_reg, appid_next;
  logic       boot;
  assign boot = (appid_reg == APPID_BOOT);
  logic [7:0] csum_addr, data_end;
  // Checksum lands right after the last payload byte in use
  assign csum_addr = 8'(REG_DATA + size_reg);
  // One past the payload store; keeps 0x8a from aliasing byte 0
  assign data_end  = 8'(REG_DATA + DATA_BYTES);

  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] off;
    off = a - REG_DATA;
    rd_mux = RST_BYTE;
    if (a == REG_APPID)
      rd_mux = appid_reg;
    else if (boot) begin
      if (a == REG_CMD)
        rd_mux = status_reg;
      else if (a == REG_SIZE)
        rd_mux = size_reg;
      else if (a == REG_CSUM)
        rd_mux = csum_reg;
      else if (a >= REG_DATA && a < data_end)
        rd_mux = mem[off[6:0]];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link receiver and read shifter
  logic [4:0]  bit_cnt_reg, bit_cnt_next;
  logic [15:0] rx_reg, rx_next;
  logic [7:0]  tx_reg, tx_next;
  logic        rd_reg, rd_next, miso_reg, miso_next, wr_stb;
  logic [7:0]  wr_addr, wr_data;
  assign wr_addr = rx_reg[14:7];
  assign wr_data = {rx_reg[6:0], mo_s2};

  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    rx_next      = rx_reg;
    tx_next      = tx_reg;
    rd_next      = rd_reg;
    miso_next    = miso_reg;
    wr_stb       = 1'b0;
    if (cs_s2) begin
      bit_cnt_next = '0;
      rd_next      = 1'b0;
    end else if (rise && bit_cnt_reg < FRAME_BITS) begin
      rx_next      = {rx_reg[14:0], mo_s2};
      bit_cnt_next = bit_cnt_reg + 5'd1;
      if (bit_cnt_reg == HDR_BITS - 5'd1) begin
        rd_next = rx_reg[7];
        tx_next = rd_mux({rx_reg[6:0], mo_s2});
      end
      if (bit_cnt_reg == FRAME_BITS - 5'd1 && !rx_reg[15])
        wr_stb = 1'b1;
    end else if (fall && rd_reg && bit_cnt_reg >= HDR_BITS) begin
      miso_next = tx_reg[7];
      tx_next   = {tx_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= '0;
      rx_reg      <= '0;
      tx_reg      <= '0;
      rd_reg      <= 1'b0;
      miso_reg    <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      rx_reg      <= rx_next;
      tx_reg      <= tx_next;
      rd_reg      <= rd_next;
      miso_reg    <= miso_next;
    end
  end
  assign lnk.link_miso = miso_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Command interpreter
  bdl_xst_t    st_reg, st_next;
  logic [7:0]  idx_reg, idx_next, acc_reg, acc_next, seed_reg, seed_next;
  logic [15:0] ptr_reg, ptr_next, ra_reg, ra_next;
  logic [7:0]  wd_reg, wd_next, off;
  logic        ptr_ok_reg, ptr_ok_next, we_reg, we_next;
  logic        remap_reg, remap_next, srst_reg, srst_next, init_reg, init_next;
  logic        mem_we;
  logic [6:0]  mem_idx;

  always_comb begin
    st_next     = st_reg;
    idx_next    = idx_reg;
    acc_next    = acc_reg;
    seed_next   = seed_reg;
    ptr_next    = ptr_reg;
    ptr_ok_next = ptr_ok_reg;
    ra_next     = ra_reg;
    wd_next     = wd_reg;
    cmd_next    = cmd_reg;
    size_next   = size_reg;
    csum_next   = csum_reg;
    status_next = status_reg;
    appid_next  = appid_reg;
    remap_next  = remap_reg;
    we_next     = 1'b0;
    srst_next   = 1'b0;
    init_next   = 1'b0;
    mem_we      = 1'b0;
    off         = wr_addr - REG_DATA;
    mem_idx     = off[6:0];
    case (st_reg)
      X_IDLE: begin
        if (wr_stb && boot) begin
          if (wr_addr == REG_CMD)
            cmd_next = wr_data;
          else if (wr_addr == REG_SIZE)
            size_next = wr_data;
          else if (wr_addr == csum_addr || wr_addr == REG_CSUM) begin
            csum_next = wr_data;
            acc_next  = cmd_reg + size_reg;
            idx_next  = '0;
            st_next   = X_SUM;
          end
          else if (wr_addr >= REG_DATA && wr_addr < data_end)
            mem_we = 1'b1;
        end
      end
      X_SUM: begin
        if (idx_reg < size_reg && idx_reg < MAX_PAYLOAD) begin
          acc_next = acc_reg + mem[idx_reg[6:0]];
          idx_next = idx_reg + 8'd1;
        end else
          st_next = X_CHECK;
      end
      X_CHECK: begin
        st_next     = X_IDLE;
        status_next = ST_OK;
        if ((acc_reg ^ CSUM_INV) != csum_reg)
          status_next = ST_CSUM;
        else begin
          case (cmd_reg)
            CMD_REMAP: begin
              if (size_reg != SIZE_REMAP)
                status_next = ST_SIZE;
              else begin
                remap_next = 1'b1;
                srst_next  = 1'b1;
                appid_next = APP_ID;
              end
            end
            CMD_INIT: begin
              if (size_reg != SIZE_INIT)
                status_next = ST_SIZE;
              else begin
                init_next = 1'b1;
                seed_next = mem[0];
              end
            end
            CMD_ADDR: begin
              if (size_reg != SIZE_ADDR)
                status_next = ST_SIZE;
              else begin
                ptr_next    = {mem[1], mem[0]};
                ptr_ok_next = 1'b1;
              end
            end
            CMD_WRAM: begin
              if (size_reg > MAX_PAYLOAD)
                status_next = ST_SIZE;
              else if (!ptr_ok_reg)
                status_next = ST_PTR;
              else begin
                idx_next = '0;
                st_next  = X_WRITE;
              end
            end
            default: status_next = ST_CMD;
          endcase
        end
      end
      X_WRITE: begin
        if (idx_reg < size_reg) begin
          we_next  = 1'b1;
          ra_next  = ptr_reg;
          wd_next  = mem[idx_reg[6:0]];
          ptr_next = ptr_reg + 16'd1;
          idx_next = idx_reg + 8'd1;
        end else
          st_next = X_IDLE;
      end
      default: st_next = X_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg     <= X_IDLE;
      idx_reg    <= '0;
      acc_reg    <= '0;
      seed_reg   <= '0;
      ptr_reg    <= '0;
      ptr_ok_reg <= 1'b0;
      ra_reg     <= '0;
      wd_reg     <= '0;
      cmd_reg    <= RST_BYTE;
      size_reg   <= RST_BYTE;
      csum_reg   <= RST_BYTE;
      status_reg <= ST_OK;
      appid_reg  <= APPID_BOOT;
      remap_reg  <= 1'b0;
      we_reg     <= 1'b0;
      srst_reg   <= 1'b0;
      init_reg   <= 1'b0;
    end else begin
      st_reg     <= st_next;
      idx_reg    <= idx_next;
      acc_reg    <= acc_next;
      seed_reg   <= seed_next;
      ptr_reg    <= ptr_next;
      ptr_ok_reg <= ptr_ok_next;
      ra_reg     <= ra_next;
      wd_reg     <= wd_next;
      cmd_reg    <= cmd_next;
      size_reg   <= size_next;
      csum_reg   <= csum_next;
      status_reg <= status_next;
      appid_reg  <= appid_next;
      remap_reg  <= remap_next;
      we_reg     <= we_next;
      srst_reg   <= srst_next;
      init_reg   <= init_next;
    end
  end

  // Payload store has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (mem_we)
      mem[mem_idx] <= wr_data;
  end

  assign ram_we    = we_reg;
  assign ram_addr  = ra_reg;
  assign ram_wdata = wd_reg;
  assign remap     = remap_reg;
  assign sys_reset = srst_reg;
  assign dl_init   = init_reg;
  assign dl_seed   = seed_reg;
endmodule

/* inc/bdl_pkg.sv */
// Shared constants and types of the boot download loader, both ends.
// Assumes a single clock per end; the link is a 4-wire serial register window.
package bdl_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register window of the device
  localparam logic [7:0] REG_APPID   = 8'h00;
  localparam logic [7:0] REG_CMD     = 8'h08;
  localparam logic [7:0] REG_SIZE    = 8'h09;
  localparam logic [7:0] REG_DATA    = 8'h0a;
  localparam logic [7:0] REG_CSUM    = 8'h8b;
  localparam int         DATA_BYTES  = 128;
  localparam logic [7:0] MAX_PAYLOAD = 8'h80;
  localparam logic [7:0] APPID_BOOT  = 8'h80;
  localparam logic [7:0] CSUM_INV    = 8'hff;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Commands, payload sizes, status codes
  localparam logic [7:0] CMD_REMAP   = 8'h11;
  localparam logic [7:0] CMD_INIT    = 8'h14;
  localparam logic [7:0] CMD_WRAM    = 8'h41;
  localparam logic [7:0] CMD_ADDR    = 8'h43;
  localparam logic [7:0] SIZE_REMAP  = 8'h00;
  localparam logic [7:0] SIZE_INIT   = 8'h01;
  localparam logic [7:0] SIZE_ADDR   = 8'h02;
  localparam logic [7:0] ST_OK       = 8'h00;
  localparam logic [7:0] ST_CSUM     = 8'h01;
  localparam logic [7:0] ST_CMD      = 8'h02;
  localparam logic [7:0] ST_SIZE     = 8'h03;
  localparam logic [7:0] ST_PTR      = 8'h04;
  ////////////////////////////////////////////////////////////////////////////
  // Link frame: rw bit, 8 address bits, 8 data bits, msb first
  localparam logic [4:0] FRAME_BITS  = 5'd17;
  localparam logic [4:0] HDR_BITS    = 5'd9;
  localparam int         LINK_HALF   = 8;
  ////////////////////////////////////////////////////////////////////////////
  // Host APB registers
  localparam logic [7:0] HA_CTRL     = 8'h00;
  localparam logic [7:0] HA_DATA     = 8'h04;
  localparam logic [7:0] HA_STAT     = 8'h08;
  localparam logic [7:0] HA_ISTAT    = 8'h0c;
  localparam logic [7:0] HA_ICLR     = 8'h10;
  localparam logic [7:0] HA_IEN      = 8'h14;
  localparam int         CTRL_SEND   = 0;
  localparam int         CTRL_POLL   = 1;
  localparam int         EV_FRAME    = 0;
  localparam int         EV_POLL     = 1;
  localparam int         EV_ERR      = 2;
  localparam int         EV_BITS     = 3;

  typedef enum logic [1:0] {X_IDLE, X_SUM, X_CHECK, X_WRITE} bdl_xst_t;
  typedef enum logic [2:0] {H_IDLE, H_LOAD, H_LOW, H_HIGH, H_GAP} bdl_hst_t;
endpackage

/* inc/bdl_link_if.sv */
// Serial register link between the host controller and the device.
// Assumes the host drives clock, select and data out; the device answers on miso.
`timescale 1ns/1ps
interface bdl_link_if;
  logic link_clk;
  logic link_cs_b;
  logic link_mosi;
  logic link_miso;
  modport host (output link_clk, output link_cs_b, output link_mosi, input link_miso);
  modport dev  (input link_clk, input link_cs_b, input link_mosi, output link_miso);
endinterface

/* core/bdl_host.sv */
// Host end: APB-controlled frame sender for the bootloader link.
// Assumes software loads payload via APB before starting; link_miso is asynchronous.
`timescale 1ns/1ps
module bdl_host
  import bdl_pkg::*;
#(
  parameter int HALF = LINK_HALF
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  bdl_link_if.host         lnk
);
  import bdl_pkg::*;

  logic mi_s1, mi_s2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mi_s1 <= 1'b0;
      mi_s2 <= 1'b0;
    end else begin
      mi_s1 <= lnk.link_miso;
      mi_s2 <= mi_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]  buf_mem [DATA_BYTES];
  bdl_hst_t    st_reg, st_next;
  logic [7:0]  cmd_reg, cmd_next, size_reg, size_next, fill_reg, fill_next;
  logic [7:0]  idx_reg, idx_next, acc_reg, acc_next, rx_reg, rx_next;
  logic [7:0]  lstat_reg, lstat_next, lcsum_reg, lcsum_next, byte_v;
  logic [16:0] sh_reg, sh_next;
  logic [4:0]  bit_reg, bit_next;
  logic [15:0] div_reg, div_next;
  logic        poll_reg, poll_next, lclk_reg, lclk_next, cs_b_reg, cs_b_next;
  logic        mosi_reg, mosi_next, rdy_reg, rdy_next, buf_we;
  logic [31:0] prd_reg, prd_next;
  logic [EV_BITS-1:0] ist_reg, ist_next, ien_reg, ien_next, ev;
  logic        irq_reg, irq_next, wr_acc, busy;
  logic [6:0]  bidx;

  assign busy   = (st_reg != H_IDLE);
  assign wr_acc = psel & penable & rdy_reg & pwrite;
  assign bidx   = 7'(idx_reg - 8'd2);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, no wait states; writes act at the access edge
  always_comb begin
    rdy_next = 1'b0;
    prd_next = '0;
    if (psel && !penable) begin
      rdy_next = 1'b1;
      case (paddr)
        HA_STAT:  prd_next = {8'h00, lcsum_reg, lstat_reg, 7'h00, busy};
        HA_ISTAT: prd_next = {{(32-EV_BITS){1'b0}}, ist_reg};
        HA_IEN:   prd_next = {{(32-EV_BITS){1'b0}}, ien_reg};
        HA_CTRL:  prd_next = {8'h00, size_reg, cmd_reg, 8'h00};
        default:  prd_next = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer and link shifter
  always_comb begin
    st_next    = st_reg;
    cmd_next   = cmd_reg;
    size_next  = size_reg;
    fill_next  = fill_reg;
    idx_next   = idx_reg;
    acc_next   = acc_reg;
    rx_next    = rx_reg;
    lstat_next = lstat_reg;
    lcsum_next = lcsum_reg;
    sh_next    = sh_reg;
    bit_next   = bit_reg;
    div_next   = div_reg;
    poll_next  = poll_reg;
    lclk_next  = lclk_reg;
    cs_b_next  = cs_b_reg;
    mosi_next  = mosi_reg;
    ien_next   = ien_reg;
    ev         = '0;
    buf_we     = 1'b0;
    byte_v     = buf_mem[bidx];
    if (idx_reg == 8'd0)
      byte_v = cmd_reg;
    else if (idx_reg == 8'd1)
      byte_v = size_reg;
    else if (idx_reg == size_reg + 8'd2)
      byte_v = acc_reg ^ CSUM_INV;
    if (wr_acc && paddr == HA_IEN)
      ien_next = pwdata[EV_BITS-1:0];
    if (wr_acc && paddr == HA_DATA && !busy) begin
      buf_we    = 1'b1;
      fill_next = fill_reg + 8'd1;
    end
    case (st_reg)
      H_IDLE: begin
        if (wr_acc && paddr == HA_CTRL) begin
          cmd_next  = pwdata[15:8];
          size_next = pwdata[23:16];
          idx_next  = '0;
          acc_next  = '0;
          poll_next = pwdata[CTRL_POLL];
          if (pwdata[CTRL_SEND] || pwdata[CTRL_POLL])
            st_next = H_LOAD;
        end
      end
      H_LOAD: begin
        if (poll_reg)
          sh_next = {1'b1, REG_CMD, RST_BYTE};
        else begin
          sh_next = {1'b0, 8'(REG_CMD + idx_reg), byte_v};
          acc_next = acc_reg + byte_v;
          if (idx_reg == size_reg + 8'd2)
            lcsum_next = byte_v;
        end
        mosi_next = poll_reg ? 1'b1 : 1'b0;
        cs_b_next = 1'b0;
        bit_next  = '0;
        div_next  = '0;
        st_next   = H_LOW;
      end
      H_LOW: begin
        div_next = div_reg + 16'd1;
        if (div_reg == 16'(HALF - 1)) begin
          div_next  = '0;
          lclk_next = 1'b1;
          st_next   = H_HIGH;
        end
      end
      H_HIGH: begin
        div_next = div_reg + 16'd1;
        if (div_reg == 16'(HALF - 1)) begin
          div_next  = '0;
          lclk_next = 1'b0;
          rx_next   = {rx_reg[6:0], mi_s2};
          sh_next   = {sh_reg[15:0], 1'b0};
          bit_next  = bit_reg + 5'd1;
          mosi_next = sh_reg[15];
          st_next   = H_LOW;
          if (bit_reg == FRAME_BITS - 5'd1) begin
            cs_b_next = 1'b1;
            mosi_next = 1'b0;
            st_next   = H_GAP;
          end
        end
      end
      H_GAP: begin
        div_next = div_reg + 16'd1;
        if (div_reg == 16'(HALF - 1)) begin
          div_next = '0;
          if (poll_reg) begin
            lstat_next  = rx_reg;
            ev[EV_POLL] = 1'b1;
            ev[EV_ERR]  = (rx_reg != ST_OK);
            st_next     = H_IDLE;
          end else if (idx_reg == size_reg + 8'd2) begin
            ev[EV_FRAME] = 1'b1;
            fill_next    = '0;
            st_next      = H_IDLE;
          end else begin
            idx_next = idx_reg + 8'd1;
            st_next  = H_LOAD;
          end
        end
      end
      default: st_next = H_IDLE;
    endcase
    // Set wins over a clear in the same cycle
    ist_next = ist_reg & ~((wr_acc && paddr == HA_ICLR) ? pwdata[EV_BITS-1:0] : '0) | ev;
    irq_next = |(ist_next & ien_next);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg    <= H_IDLE;
      cmd_reg   <= '0;
      size_reg  <= '0;
      fill_reg  <= '0;
      idx_reg   <= '0;
      acc_reg   <= '0;
      rx_reg    <= '0;
      lstat_reg <= '0;
      lcsum_reg <= '0;
      sh_reg    <= '0;
      bit_reg   <= '0;
      div_reg   <= '0;
      poll_reg  <= 1'b0;
      lclk_reg  <= 1'b0;
      cs_b_reg  <= 1'b1;
      mosi_reg  <= 1'b0;
      rdy_reg   <= 1'b0;
      prd_reg   <= '0;
      ist_reg   <= '0;
      ien_reg   <= '0;
      irq_reg   <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cmd_reg   <= cmd_next;
      size_reg  <= size_next;
      fill_reg  <= fill_next;
      idx_reg   <= idx_next;
      acc_reg   <= acc_next;
      rx_reg    <= rx_next;
      lstat_reg <= lstat_next;
      lcsum_reg <= lcsum_next;
      sh_reg    <= sh_next;
      bit_reg   <= bit_next;
      div_reg   <= div_next;
      poll_reg  <= poll_next;
      lclk_reg  <= lclk_next;
      cs_b_reg  <= cs_b_next;
      mosi_reg  <= mosi_next;
      rdy_reg   <= rdy_next;
      prd_reg   <= prd_next;
      ist_reg   <= ist_next;
      ien_reg   <= ien_next;
      irq_reg   <= irq_next;
    end
  end

  // Payload buffer, filled in order by DATA writes
  always_ff @(posedge clk) begin
    if (buf_we)
      buf_mem[fill_reg[6:0]] <= pwdata[7:0];
  end

  assign prdata         = prd_reg;
  assign pready         = rdy_reg;
  assign pslverr        = 1'b0;
  assign irq            = irq_reg;
  assign lnk.link_clk   = lclk_reg;
  assign lnk.link_cs_b  = cs_b_reg;
  assign lnk.link_mosi  = mosi_reg;
endmodule

/* verification/bdl_properties.sv */
// Checker on the serial link between the two ends.
// Assumes host HALF is 8 and one clk domain.
`timescale 1ns/1ps
module bdl_properties
  import bdl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic link_cs_b,
  input wire logic link_mosi,
  input wire logic link_miso
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic       clk_q_reg, clk_q_next;
  logic [4:0] edges_reg, edges_next;
  //////////////////////////////
  // Rising link edges in the open frame
  always_comb begin
    clk_q_next = link_clk;
    edges_next = edges_reg;
    if (link_cs_b) begin
      edges_next = 5'h00;
    end else if (link_clk && !clk_q_reg) begin
      edges_next = edges_reg + 5'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_q_reg <= 1'b0;
      edges_reg <= 5'h00;
    end else begin
      clk_q_reg <= clk_q_next;
      edges_reg <= edges_next;
    end
  end
  //////////////////////////////
  idle_clk_low_a: assert property (link_cs_b |-> !link_clk)
    else $error("link clock high outside frame");
  mosi_shift_a: assert property ($changed(link_mosi) |-> !link_clk)
    else $error("mosi moved while clock high");
  gap_len_a: assert property ($rose(link_cs_b) |-> link_cs_b [*8])
    else $error("frame gap too short");
  high_phase_a: assert property ($rose(link_clk) |-> link_clk [*8] ##1 !link_clk)
    else $error("clock high phase not eight");
  low_phase_a: assert property ($fell(link_clk) |-> !link_clk [*8])
    else $error("clock low phase short");
  frame_bits_a: assert property ($rose(link_cs_b) |-> edges_reg == FRAME_BITS)
    else $error("frame bit count wrong");
  miso_shift_a: assert property ($changed(link_miso) |-> !link_clk)
    else $error("miso moved while clock high");
  frame_start_a: assert property ($fell(link_cs_b) |-> !link_clk [*8] ##1 link_clk)
    else $error("first bit setup wrong");
endmodule

/* verification/boot_ram_download_loader_tb.sv */
// Bench: APB host end talking to the device end over the link.
// Assumes package constants and host HALF default.
`timescale 1ns/1ps
module boot_ram_download_loader_tb;
  import bdl_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, ram_wdata, dl_seed;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, ram_we, remap, sys_reset, dl_init, got_init = 1'b0, got_rst = 1'b0;
  logic [15:0] ram_addr;
  logic [23:0] seen[$];
  int          n_errors = 0, checks = 0, cyc = 0;
  always #10 clk = ~clk;
  bdl_link_if bdl_link_if_i ();
  bdl_host bdl_host_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .lnk(bdl_link_if_i));
  bdl_dev bdl_dev_i (.clk(clk), .rst_b(rst_b), .lnk(bdl_link_if_i), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .remap(remap), .sys_reset(sys_reset), .dl_init(dl_init), .dl_seed(dl_seed));
  bdl_properties bdl_properties_i (.clk(clk), .rst_b(rst_b), .link_clk(bdl_link_if_i.link_clk),
    .link_cs_b(bdl_link_if_i.link_cs_b), .link_mosi(bdl_link_if_i.link_mosi),
    .link_miso(bdl_link_if_i.link_miso));
  //////////////////////////////
  always @(posedge clk) begin
    if (ram_we === 1'b1) seen.push_back({ram_addr, ram_wdata});
    if (dl_init === 1'b1) got_init <= 1'b1;
    if (sys_reset === 1'b1) got_rst <= 1'b1;
  end
  // Far above the roughly 14k cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic wait_irq;
    while (irq !== 1'b1) @(posedge clk);
    wr(HA_ICLR, 32'h7);
  endtask
  task automatic frame(input logic [7:0] cmd, sz, b0, b1, b2, st);
    logic [31:0] r;
    logic [7:0]  sum;
    logic [7:0]  bb[3];
    bb = '{b0, b1, b2};
    sum = cmd + sz;
    for (int i = 0; i < sz; i++) begin
      wr(HA_DATA, {24'h0, bb[i]});
      sum += bb[i];
    end
    wr(HA_CTRL, {8'h00, sz, cmd, 8'h01});
    wait_irq();
    apb(1'b0, HA_STAT, 32'h0, r);
    check(r[23:16], sum ^ CSUM_INV);
    wr(HA_CTRL, 32'h2);
    wait_irq();
    apb(1'b0, HA_STAT, 32'h0, r);
    check(r[15:8], st);
  endtask
  //////////////////////////////
  task automatic t_codes;
    frame(CMD_WRAM, 8'h01, 8'h5a, 8'h00, 8'h00, ST_PTR);
    frame(8'h55, 8'h00, 8'h00, 8'h00, 8'h00, ST_CMD);
    frame(CMD_INIT, 8'h00, 8'h00, 8'h00, 8'h00, ST_SIZE);
    frame(CMD_INIT, SIZE_INIT, 8'hc3, 8'h00, 8'h00, ST_OK);
    check(got_init, 1'b1);
    check(dl_seed, 8'hc3);
  endtask
  task automatic t_write;
    logic [23:0] exp[4];
    exp = '{24'h1234a1, 24'h1235a2, 24'h1236a3, 24'h1237b4};
    frame(CMD_ADDR, SIZE_ADDR, 8'h34, 8'h12, 8'h00, ST_OK);
    frame(CMD_WRAM, 8'h03, 8'ha1, 8'ha2, 8'ha3, ST_OK);
    frame(CMD_WRAM, 8'h01, 8'hb4, 8'h00, 8'h00, ST_OK);
    check(seen.size(), 4);
    for (int i = 0; i < 4; i++) check(seen[i], exp[i]);
  endtask
  task automatic t_remap;
    logic [31:0] r;
    frame(CMD_REMAP, SIZE_REMAP, 8'h00, 8'h00, 8'h00, ST_OK);
    apb(1'b0, HA_STAT, 32'h0, r);
    check(r[23:16], 8'hee);
    check({remap, got_rst}, 2'b11);
    // Boot window closed: a seed frame must not land
    frame(CMD_INIT, SIZE_INIT, 8'h99, 8'h00, 8'h00, ST_OK);
    check(dl_seed, 8'hc3);
    wr(HA_IEN, 32'h0);
    wr(HA_CTRL, 32'h2);
    do apb(1'b0, HA_ISTAT, 32'h0, r); while (r[1] !== 1'b1);
    check(irq, 1'b0);
    check(r[2], 1'b0);
    wr(HA_ICLR, 32'h7);
    apb(1'b0, HA_ISTAT, 32'h0, r);
    check(r, 32'h0);
    // Enable pin toggle reopens the boot window
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check(remap, 1'b0);
    wr(HA_IEN, 32'h7);
    frame(8'h55, 8'h00, 8'h00, 8'h00, 8'h00, ST_CMD);
  endtask
  initial begin
    logic [31:0] r;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, HA_STAT, 32'h0, r);
    check(r, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r);
    check(r, 32'h0);
    wr(HA_IEN, 32'h7);
    t_codes();
    t_write();
    t_remap();
    stop_test();
  end
endmodule
